// File: hw/ddspl_core.sv
// Synthesizer core with profiles, sweep, sleep and phase detector / pump control
//
// Function
// R1: 32-bit phase accumulator advances by the tuning word every system clock.
// R2: 14-bit phase offset added to phase before sine conversion.
// R3: Output frequency is tuning word times clock rate over two to the 32.
// R4: Four profiles, active one chosen by two profile select pins.
// R5: Each profile holds own tuning word and phase offset, both feed core.
// R6: Optional divide-by-two of reference gives the system clock enable.
// R7: Single-tone and automated frequency-sweep modes.
// R8: Full-sleep mode halts most logic to save current.
// R9: Host writes all settings into on-chip registers.
// R10: Core delivers 10-bit sine samples, true and complementary, to converter.
// R11: Each detector input has a divider of 1, 2 or 4 set by control field.
// R12: Positive polarity: feedback leads lowers control voltage, lags raises it.
// R13: Negative polarity: feedback leads raises control voltage, lags lowers it.
// R14: Polarity bit resets to 0, ground-referenced; 1 supply-referenced.
// R15: Final closed-loop current scale is 1, 2, 3 or 4 times base.
// R16: Wide closed-loop current scale is 0 to 14 in steps of two.
// R17: Frequency-detect current scale is 0, 20, 40 or 60 times base.
// R18: Host drives profile select pins synchronous to the sync clock output.
// R19: Rising edge of update strobe copies buffered settings to active ones.
// R20: Sync clock output runs at one eighth of the reference rate.
// R21: Frequency changes keep accumulator phase, no reset on update.
// R22: Offset added to top accumulator bits, sine lookup gives converter word.
// R23: Reset clears accumulator and restores every setting to its default.
`timescale 1ns/10ps
module ddspl_core
  import ddspl_pkg::*;
(
  // Clock and reset (clock is the reference)
  input  wire logic               i_mclk,
  input  wire logic               i_sys_rst,
  // Static configuration
  input  wire logic               i_clk_div2_en,
  // Host register writes
  input  wire ddspl_wr_t          i_wr,
  input  wire logic               i_wr_valid,
  // Pins from the other party
  input  wire logic [1:0]         i_profile_select_pins,
  input  wire logic               i_update_strobe,
  input  wire logic               i_reference_phase_input,
  input  wire logic               i_feedback_phase_input,
  // Converter samples
  output logic [DAC_W-1:0]        o_dac_p,
  output logic [DAC_W-1:0]        o_dac_n,
  // Sync clock and status
  output logic                    o_sync_clock_out,
  output logic                    o_sleeping,
  // Pump controls
  output logic                    o_pump_up,
  output logic                    o_pump_down,
  output logic [6:0]              o_final_mult,
  output logic [6:0]              o_wide_mult,
  output logic [6:0]              o_fdet_mult
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Quarter-wave sine table, 6-bit index, 9-bit magnitude
  function automatic logic [DAC_W-2:0] sine_q(input logic [LUT_AW-1:0] idx);
    logic [DAC_W-2:0] tbl [0:63];
    tbl = '{9'h006, 9'h013, 9'h01f, 9'h02c, 9'h038, 9'h045, 9'h051, 9'h05e,
            9'h06a, 9'h076, 9'h082, 9'h08e, 9'h09a, 9'h0a6, 9'h0b2, 9'h0be,
            9'h0c9, 9'h0d5, 9'h0e0, 9'h0eb, 9'h0f6, 9'h101, 9'h10c, 9'h117,
            9'h121, 9'h12b, 9'h135, 9'h13f, 9'h149, 9'h152, 9'h15c, 9'h165,
            9'h16e, 9'h176, 9'h17f, 9'h187, 9'h18f, 9'h197, 9'h19e, 9'h1a5,
            9'h1ac, 9'h1b3, 9'h1b9, 9'h1c0, 9'h1c6, 9'h1cb, 9'h1d1, 9'h1d6,
            9'h1da, 9'h1df, 9'h1e3, 9'h1e7, 9'h1eb, 9'h1ee, 9'h1f1, 9'h1f4,
            9'h1f6, 9'h1f9, 9'h1fa, 9'h1fc, 9'h1fd, 9'h1fe, 9'h1ff, 9'h1ff};
    return tbl[idx];
  endfunction

  // Divider ratio code to terminal count (1, 2 or 4)
  function automatic logic [1:0] div_last(input logic [1:0] code);
    case (code)
      DIV_BY2: return 2'h1;
      DIV_BY4: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [1:0] ps_s1, ps_s2;
  logic [3:0] in_s1, in_s2;
  logic       upd_d;

  // Two flops on every pin
  always_ff @(posedge i_mclk) begin
    ps_s1 <= i_profile_select_pins;
    ps_s2 <= ps_s1;
    in_s1 <= {i_update_strobe, i_reference_phase_input, i_feedback_phase_input, i_clk_div2_en};
    in_s2 <= in_s1;
  end

  wire upd_s  = in_s2[3];
  wire ref_s  = in_s2[2];
  wire fb_s   = in_s2[1];
  wire div2_s = in_s2[0];

  ////////////////////////////////////////////////////////////////////////////
  // System clock enable and sync clock

  logic       half_tgl;
  logic [2:0] sync_cnt;
  wire        sys_en = ~div2_s | half_tgl;                 // [R6]

  // Divide-by-two toggle and eighth-rate counter
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      half_tgl         <= 1'b0;
      sync_cnt         <= 3'h0;
      o_sync_clock_out <= 1'b0;
    end else begin
      half_tgl         <= ~half_tgl;                       // [R6]
      sync_cnt         <= sync_cnt + 3'h1;
      o_sync_clock_out <= (sync_cnt >= 3'(SYNC_HALF - 1)) && (sync_cnt != 3'(SYNC_DIV - 1)); // [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffered and active settings

  ddspl_prof_t buf_prof [NPROF];
  ddspl_prof_t act_prof [NPROF];
  ddspl_pll_t  buf_pll, act_pll;
  ddspl_mode_t buf_mode, act_mode;
  logic [ACC_W-1:0] buf_step, act_step;
  wire  upd_rise = upd_s & ~upd_d;

  // Host writes land in buffers; update edge copies to active
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NPROF; i++) begin
        buf_prof[i] <= '{TUNING_RST, POFS_RST};           // [R23]
        act_prof[i] <= '{TUNING_RST, POFS_RST};
      end
      buf_pll  <= '{DIV_RST, DIV_RST, POL_RST, FINAL_RST, WIDE_RST, FDET_RST}; // [R14]
      act_pll  <= '{DIV_RST, DIV_RST, POL_RST, FINAL_RST, WIDE_RST, FDET_RST};
      buf_mode <= DDSPL_SINGLE;
      act_mode <= DDSPL_SINGLE;
      buf_step <= TUNING_RST;
      act_step <= TUNING_RST;
      upd_d    <= 1'b0;
    end else begin
      upd_d <= upd_s;
      if (i_wr_valid && i_wr.prof_we) buf_prof[i_wr.prof_idx] <= i_wr.prof;  // [R9]
      if (i_wr_valid && i_wr.pll_we)  buf_pll <= i_wr.pll;
      if (i_wr_valid && i_wr.mode_we) begin
        buf_mode <= i_wr.mode;
        buf_step <= i_wr.sweep_step;
      end
      if (upd_rise) begin                                  // [R19]
        act_prof <= buf_prof;
        act_pll  <= buf_pll;
        act_mode <= buf_mode;
        act_step <= buf_step;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator

  logic [ACC_W-1:0] phase_acc, sweep_ofs;
  wire  ddspl_prof_t sel_prof = act_prof[ps_s2];           // [R4] [R5] [R18]
  wire  sleep_n = (act_mode != DDSPL_SLEEP);
  wire  [ACC_W-1:0] eff_tw = sel_prof.tuning_word + sweep_ofs;

  // Accumulator: phase-continuous, never reloaded by updates
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      phase_acc <= '0;                                     // [R23]
      sweep_ofs <= '0;
    end else if (sys_en && sleep_n) begin                  // [R8]
      phase_acc <= phase_acc + eff_tw;                     // [R1] [R3] [R21]
      if (act_mode == DDSPL_SWEEP)
        sweep_ofs <= sweep_ofs + act_step;                 // [R7]
      else
        sweep_ofs <= '0;
    end
  end

  // Offset and sine lookup
  wire [POFS_W-1:0] ph = phase_acc[ACC_W-1 -: POFS_W] + sel_prof.phase_ofs;  // [R2] [R22]
  wire [LUT_AW-1:0] qidx = ph[POFS_W-2] ? ~ph[POFS_W-3 -: LUT_AW] : ph[POFS_W-3 -: LUT_AW];
  wire [DAC_W-2:0]  mag  = sine_q(qidx);
  wire [DAC_W-1:0]  samp = ph[POFS_W-1] ? (10'h200 - {1'b0, mag}) : (10'h200 + {1'b0, mag}); // [R22]

  // Converter outputs, held at their last sample in sleep
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_dac_p    <= 10'h200;
      o_dac_n    <= 10'h1ff;
      o_sleeping <= 1'b0;
    end else begin
      o_sleeping <= ~sleep_n;
      if (sys_en && sleep_n) begin
        o_dac_p <= samp;                                   // [R10]
        o_dac_n <= ~samp;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector input dividers and phase comparison

  logic [1:0] rcnt, fcnt;
  logic       rdiv, fdiv, rdiv_d, fdiv_d, lead_up, lead_dn;

  // Dividers count input rising edges (1, 2 or 4)
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rcnt <= 2'h0; fcnt <= 2'h0;
      rdiv <= 1'b0; fdiv <= 1'b0;
      rdiv_d <= 1'b0; fdiv_d <= 1'b0;
    end else begin
      rdiv <= 1'b0;
      fdiv <= 1'b0;
      rdiv_d <= ref_s;
      fdiv_d <= fb_s;
      if (ref_s && !rdiv_d) begin
        rcnt <= (rcnt >= div_last(act_pll.ref_div)) ? 2'h0 : rcnt + 2'h1; // [R11]
        rdiv <= (rcnt >= div_last(act_pll.ref_div));
      end
      if (fb_s && !fdiv_d) begin
        fcnt <= (fcnt >= div_last(act_pll.fb_div)) ? 2'h0 : fcnt + 2'h1;  // [R11]
        fdiv <= (fcnt >= div_last(act_pll.fb_div));
      end
    end
  end

  // Tri-state detector: feedback first sets down, reference first sets up
  wire both = (lead_up | rdiv) & (lead_dn | fdiv);
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      lead_up     <= 1'b0;
      lead_dn     <= 1'b0;
      o_pump_up   <= 1'b0;
      o_pump_down <= 1'b0;
    end else begin
      lead_up <= both ? 1'b0 : (lead_up | rdiv);
      lead_dn <= both ? 1'b0 : (lead_dn | fdiv);
      o_pump_up   <= act_pll.pump_polarity_select ? lead_dn : lead_up; // [R12] [R13] [R14]
      o_pump_down <= act_pll.pump_polarity_select ? lead_up : lead_dn; // [R12] [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pump current multipliers

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_final_mult <= 7'h00;
      o_wide_mult  <= 7'h00;
      o_fdet_mult  <= 7'h00;
    end else begin
      o_final_mult <= 7'(act_pll.final_scale + 2'h0) * FINAL_STEP + FINAL_STEP; // [R15]
      o_wide_mult  <= 7'(act_pll.wide_scale) * WIDE_STEP;                      // [R16]
      o_fdet_mult  <= 7'(act_pll.fdet_scale) * FDET_STEP;                      // [R17]
    end
  end

endmodule // ddspl_core

// File: common/ddspl_pkg.sv
// Package: constants and carrier types for the synthesizer core and loop control
package ddspl_pkg;

  // Datapath widths
  localparam int ACC_W    = 32;
  localparam int POFS_W   = 14;
  localparam int DAC_W    = 10;
  localparam int LUT_AW   = 6;
  localparam int NPROF    = 4;

  // Reset values
  localparam logic [ACC_W-1:0]  TUNING_RST  = 32'h0000_0000;
  localparam logic [POFS_W-1:0] POFS_RST    = 14'h0000;
  localparam logic              POL_RST     = 1'h0;
  localparam logic [1:0]        DIV_RST     = 2'h0;
  localparam logic [1:0]        FINAL_RST   = 2'h0;
  localparam logic [2:0]        WIDE_RST    = 3'h0;
  localparam logic [1:0]        FDET_RST    = 2'h0;

  // Divider codes for the detector inputs
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;

  // Pump scaling steps
  localparam logic [6:0] FINAL_STEP = 7'h01;
  localparam logic [6:0] WIDE_STEP  = 7'h02;
  localparam logic [6:0] FDET_STEP  = 7'h14;

  // Sync clock output: one eighth of the reference
  localparam int SYNC_DIV = 8;
  localparam int SYNC_HALF = SYNC_DIV / 2;

  // Core operating modes
  typedef enum logic [1:0] {DDSPL_SINGLE, DDSPL_SWEEP, DDSPL_SLEEP} ddspl_mode_t;

  // One profile: tuning word and phase offset
  typedef struct packed {
    logic [ACC_W-1:0]  tuning_word;
    logic [POFS_W-1:0] phase_ofs;
  } ddspl_prof_t;

  // Phase detector and pump settings
  typedef struct packed {
    logic [1:0] ref_div;
    logic [1:0] fb_div;
    logic       pump_polarity_select;
    logic [1:0] final_scale;
    logic [2:0] wide_scale;
    logic [1:0] fdet_scale;
  } ddspl_pll_t;

  // Host write of one buffered item
  typedef struct packed {
    logic              prof_we;
    logic [1:0]        prof_idx;
    ddspl_prof_t       prof;
    logic              pll_we;
    ddspl_pll_t        pll;
    logic              mode_we;
    ddspl_mode_t       mode;
    logic [ACC_W-1:0]  sweep_step;
  } ddspl_wr_t;

endpackage

// File: verif/ddspl_core_properties.sv
// Checker: port-level properties of the synthesizer core
`timescale 1ns/10ps
module ddspl_core_properties
  import ddspl_pkg::*;
(
  // Clock and reset
  input wire logic             i_mclk,
  input wire logic             i_sys_rst,
  // Observed outputs
  input wire logic [DAC_W-1:0] o_dac_p,
  input wire logic [DAC_W-1:0] o_dac_n,
  input wire logic             o_sync_clock_out,
  input wire logic             o_sleeping,
  input wire logic             o_pump_up,
  input wire logic             o_pump_down,
  input wire logic [6:0]       o_final_mult,
  input wire logic [6:0]       o_wide_mult,
  input wire logic [6:0]       o_fdet_mult
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////
  // Output relations
  a_dac_complement: assert property (o_dac_n == ~o_dac_p)
    else $error("dac outputs not complementary");
  a_sync_period: assert property ($rose(o_sync_clock_out) |-> o_sync_clock_out[*4] ##1 !o_sync_clock_out[*4])
    else $error("sync clock period wrong");
  a_sync_start: assert property ($fell(i_sys_rst) |-> ##[1:8] o_sync_clock_out)
    else $error("sync clock did not start");
  a_reset_idle: assert property (disable iff (1'b0) i_sys_rst |=>
    o_dac_p == 10'h200 && o_final_mult == 7'h00 && !o_sleeping && !o_pump_up)
    else $error("reset state wrong");
  a_final_range: assert property (o_final_mult <= 7'h04)
    else $error("final scale out of range");
  a_wide_even: assert property (!o_wide_mult[0] && o_wide_mult <= 7'h0e)
    else $error("wide scale not an even step");
  a_fdet_steps: assert property (o_fdet_mult inside {7'h00, 7'h14, 7'h28, 7'h3c})
    else $error("detect scale not a step of twenty");
  a_pump_excl: assert property (!(o_pump_up && o_pump_down))
    else $error("pump up and down together");
  a_sleep_freeze: assert property (o_sleeping && $past(o_sleeping) |-> $stable(o_dac_p))
    else $error("dac moved while asleep");
  // Scenario coverage
  c_sleep: cover property (o_sleeping);
  c_up: cover property (o_pump_up);
  c_down: cover property (o_pump_down);
endmodule // ddspl_core_properties

bind ddspl_core ddspl_core_properties i_props (.i_mclk, .i_sys_rst, .o_dac_p, .o_dac_n, .o_sync_clock_out,
  .o_sleeping, .o_pump_up, .o_pump_down, .o_final_mult, .o_wide_mult, .o_fdet_mult);

// File: verif/ddspl_host_model.sv
// Host model: update strobe and profile pins in step with the sync clock
`timescale 1ns/10ps
module ddspl_host_model (
  // Clock, reset and sync clock
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_sync,
  // Bench requests
  input  wire logic       i_req,
  input  wire logic [1:0] i_prof,
  // Pins toward the core
  output logic            o_update_strobe,
  output logic [1:0]      o_profile_select_pins
);
  logic sync_q;
  logic pend;
  // Pins move only at a sync clock rise; strobe lasts one sync period
  always_ff @(posedge i_mclk) begin
    sync_q <= i_sync;
    if (i_rst) begin
      pend <= 1'b0;
      o_update_strobe <= 1'b0;
      o_profile_select_pins <= 2'h0;
    end else begin
      if (i_sync && !sync_q) begin
        o_profile_select_pins <= i_prof;
        o_update_strobe <= pend;
        pend <= 1'b0;
      end
      if (i_req) begin
        pend <= 1'b1;
      end
    end
  end
endmodule // ddspl_host_model

// File: verif/ddspl_core_tb.sv
// Testbench for the synthesizer core
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module ddspl_core_tb
  import ddspl_pkg::*;
;
  logic clk, rst, div2, wr_v, req, upd, sync, refi, fbi, up, dn, slp, su, sd;
  logic [1:0] pins, pq;
  ddspl_wr_t wr, w;
  ddspl_pll_t pll;
  logic [DAC_W-1:0] dp, dnn, d0, d2;
  logic [6:0] fm, wm, dm;
  int failures, checked;
  // Rows: scale code, final, wide, detect expected
  int pr[8][4] = '{'{0,1,0,0}, '{1,2,2,20}, '{2,3,4,40}, '{3,4,6,60}, '{4,1,8,0}, '{5,2,10,20}, '{6,3,12,40},
                   '{7,4,14,60}};
  // Rows: divider code, reference edges, polarity, up expected
  int dt[6][4] = '{'{0,1,0,1}, '{0,1,1,0}, '{0,0,0,0}, '{1,2,0,1}, '{2,4,0,1}, '{2,3,0,0}};
  ddspl_mode_t ms[3] = '{DDSPL_SWEEP, DDSPL_SLEEP, DDSPL_SINGLE};

  ddspl_core i_dut (.i_mclk(clk), .i_sys_rst(rst), .i_clk_div2_en(div2), .i_wr(wr), .i_wr_valid(wr_v),
    .i_profile_select_pins(pins), .i_update_strobe(upd), .i_reference_phase_input(refi),
    .i_feedback_phase_input(fbi), .o_dac_p(dp), .o_dac_n(dnn), .o_sync_clock_out(sync), .o_sleeping(slp),
    .o_pump_up(up), .o_pump_down(dn), .o_final_mult(fm), .o_wide_mult(wm), .o_fdet_mult(dm));
  ddspl_host_model i_host (.i_mclk(clk), .i_rst(rst), .i_sync(sync), .i_req(req), .i_prof(pq),
    .o_update_strobe(upd), .o_profile_select_pins(pins));
  ////////////////////////////////////////////////////////////
  // Bus tasks
  task automatic put();
    @(negedge clk) wr = w;
    wr_v = 1'b1;
    @(negedge clk) wr_v = 1'b0;
  endtask
  task automatic wprof(input logic [1:0] i, input logic [31:0] t, input logic [13:0] o);
    w = '0;
    w.prof_we = 1'b1;
    w.prof_idx = i;
    w.prof = '{t, o};
    put();
  endtask
  task automatic update(input logic [1:0] p);
    int n;
    @(negedge clk) pq = p;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    for (n = 0; n < 40 && upd !== 1'b1; n++) @(negedge clk);
    `CHK("update strobe", 1'b1, upd)
    repeat (8) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    close_out();
  end
  // Main sequence
  initial begin
    {rst, div2, wr_v, req, refi, fbi, pq} = 8'h80;
    wr = '0;
    pll = '0;
    failures = 0;
    checked = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    // Pump scaling rows
    for (int i = 0; i < 8; i++) begin
      pll.final_scale = 2'(pr[i][0]);
      pll.wide_scale = 3'(pr[i][0]);
      pll.fdet_scale = 2'(pr[i][0]);
      w = '0;
      w.pll_we = 1'b1;
      w.pll = pll;
      put();
      update(2'h0);
      `CHK("final", 7'(pr[i][1]), fm)
      `CHK("wide", 7'(pr[i][2]), wm)
      `CHK("fdet", 7'(pr[i][3]), dm)
    end
    $display("scaling done, failures %0d", failures);
    // Detector cases: reference edges then one feedback edge
    for (int i = 0; i < 6; i++) begin
      pll.ref_div = 2'(dt[i][0]);
      pll.pump_polarity_select = 1'(dt[i][2]);
      w.pll = pll;
      put();
      update(2'h0);
      {su, sd} = 2'h0;
      for (int c = 0; c < 4 * dt[i][1] + 12; c++) begin
        @(negedge clk) su |= up;
        sd |= dn;
        refi = (c < 4 * dt[i][1]) && (c % 4 < 2);
        fbi = (c >= 4 * dt[i][1]) && (c < 4 * dt[i][1] + 2);
      end
      `CHK("pump up", 1'(dt[i][3]), su)
      `CHK("pump down", !1'(dt[i][3]), sd)
      // Too few reference edges leave the detector pending; one more edge clears it
      if (dt[i][1] < (1 << dt[i][0])) begin
        refi = 1'b1;
        repeat (2) @(negedge clk);
        refi = 1'b0;
        repeat (8) @(negedge clk);
      end
      `CHK("pump idle", 2'h0, {up, dn})
    end
    $display("detector done, failures %0d", failures);
    // Profiles: offsets and one quarter-turn tuning word
    wprof(2'h0, 32'h0000_0000, 14'h0000);
    wprof(2'h1, 32'h0000_0000, 14'h1000);
    wprof(2'h2, 32'h0000_0000, 14'h3000);
    wprof(2'h3, 32'h4000_0000, 14'h0800);
    update(2'h0);
    // Half-step table: first magnitude sits just above midscale
    `CHK("zero phase", 10'h206, dp)
    update(2'h1);
    `CHK("quarter", 1'b1, dp > 10'h300)
    update(2'h2);
    `CHK("three quarter", 1'b1, dp < 10'h100)
    update(2'h3);
    d0 = dp;
    repeat (2) @(negedge clk);
    d2 = dp;
    repeat (2) @(negedge clk);
    `CHK("period four", d0, dp)
    `CHK("half turn", 1'b1, d2 !== d0)
    div2 = 1'b1;
    repeat (6) @(negedge clk);
    d0 = dp;
    repeat (4) @(negedge clk);
    d2 = dp;
    repeat (4) @(negedge clk);
    `CHK("div2 period", d0, dp)
    `CHK("div2 half", 1'b1, d2 !== d0)
    div2 = 1'b0;
    $display("profiles done, failures %0d", failures);
    // Modes: sweep moves, sleep freezes, single moves
    for (int i = 0; i < 3; i++) begin
      w = '0;
      w.mode_we = 1'b1;
      w.mode = ms[i];
      w.sweep_step = 32'h0100_0000;
      put();
      update(2'h3);
      `CHK("sleeping", ms[i] == DDSPL_SLEEP, slp)
      d0 = dp;
      repeat (2) @(negedge clk);
      d2 = dp;
      repeat (2) @(negedge clk);
      `CHK("frozen", ms[i] == DDSPL_SLEEP, dp === d0 && d2 === d0)
      `CHK("sweep drift", ms[i] != DDSPL_SWEEP, dp === d0)
    end
    $display("modes done, failures %0d", failures);
    // Reset in mid-run
    rst = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("dac p", 10'h200, dp)
    `CHK("dac n", 10'h1ff, dnn)
    `CHK("scales", 21'h0, {fm, wm, dm})
    rst = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("pump defaults", {7'h01, 7'h00, 7'h00}, {fm, wm, dm})
    `CHK("dac default", 10'h206, dp)
    $display("reset done, failures %0d", failures);
    close_out();
  end
endmodule // ddspl_core_tb
